/* File: common/lrgc_pkg.sv */
// Constants for the receive line gain control block.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package lrgc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int GAIN_W = 6;
    localparam int PEAK_W = 8;
    localparam int OBS_W = 11;
    localparam int RAIL_W = 2;
    localparam int FIFO_DEPTH = 16;

    // Register offsets
    localparam logic [8:0] ADDR_LINE_CFG = 9'h020;
    localparam logic [8:0] ADDR_RX_CFG = 9'h022;
    localparam logic [8:0] ADDR_GAIN_CEIL = 9'h024;
    localparam logic [8:0] ADDR_GAIN_STAT = 9'h029;

    // Field positions
    localparam int LCFG_BYPASS_BIT = 7;
    localparam int LCFG_FORCE_GAIN_BIT = 6;
    localparam int LCFG_RAIL_OE_BIT = 0;
    localparam int RXCFG_OBS_LSB = 0;
    localparam int STAT_OVF_BIT = 7;
    localparam int STAT_FULL_BIT = 6;

    // Reset values
    localparam logic [7:0] LCFG_RESET = 8'h00;
    localparam logic [7:0] RXCFG_RESET = 8'h00;
    localparam logic [5:0] CEIL_RESET = 6'h3F;
    localparam logic [5:0] GAIN_MIN = 6'h00;
    localparam logic [5:0] GAIN_STEP = 6'h01;

    // Converter window: 75 % and 100 % of full scale
    localparam logic [7:0] PEAK_LOW = 8'hC0;
    localparam logic [7:0] PEAK_FULL = 8'hFF;
    localparam logic [7:0] PEAK_CLEAR = 8'h00;

    // Last count of each observation period, in symbols
    localparam logic [10:0] OBS_LAST_32 = 11'h01F;
    localparam logic [10:0] OBS_LAST_128 = 11'h07F;
    localparam logic [10:0] OBS_LAST_512 = 11'h1FF;
    localparam logic [10:0] OBS_LAST_2048 = 11'h7FF;
    localparam logic [10:0] OBS_STEP = 11'h001;

    // Output high-impedance bound after power-up, in reference cycles
    localparam int PWRUP_HIZ_CYCLES = 3000;

    typedef enum logic [1:0] {OBS_32, OBS_128, OBS_512, OBS_2048} lrgc_obs_t;
    typedef enum {ST_START, ST_TRACK, ST_FIXED} lrgc_agc_t;
endpackage

/* File: common/lrgc_stream_if.sv */
// Valid/ready stream carrying one dual-rail symbol per beat.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface lrgc_stream_if #(parameter int W = 2);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: logic/lrgc_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes the caller gates all activity with clk_en.
`timescale 1ns/10ps
module lrgc_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    lrgc_stream_if.snk wr,
    lrgc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign wr.ready = (cnt_r != FULL_CNT);
    assign rd.valid = (cnt_r != '0);
    assign rd.data = mem_r[rp_r];

    always_comb begin
        push = clk_en & wr.valid & wr.ready;
        pop = clk_en & rd.valid & rd.ready;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= wr.data;
        end
    end
endmodule // lrgc_fifo

/* File: logic/lrgc_top.sv */
// Receive line gain control: input select, gain loop, rail output.
// Assumes sliced line symbols and converter peaks arrive on mclk;
// bypass pins are asynchronous and are synchronised here.
//
// Summary of operation
// - Bypass bit set: ignore line inputs, take rail data from bypass pins.
// - In bypass the external rail clock times symbols; far end supplies it.
// - Line pulses become separate positive and negative rail data.
// - Received rail data is also presented on the rail output pins.
// - Gain loop keeps converter signal between 75 and 100 percent scale.
// - Gain moves inversely to measured peak: larger peak, less gain.
// - Force-gain bit picks gain-limit or fixed-gain operation.
// - Gain-limit operation caps adaptive gain; it is the normal mode.
// - Gain-limit starts at maximum sensitivity, then adjusts per period.
// - Observation period is 32, 128, 512 or 2048 symbols.
// - Present gain setting is readable in the status register.
// - Fixed-gain mode applies the ceiling register value directly.
// - Ceiling register is six bits, 64 settings of 1.25 dB.
// - Outputs are high impedance within 3000 reference cycles of power.
`timescale 1ns/10ps
module lrgc_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic line_in_plus,
    input wire logic line_in_minus,
    input wire logic line_symbol_tick,
    input wire logic [7:0] adc_peak_sample,
    input wire logic adc_sample_valid,
    input wire logic bypass_pos_rail_in,
    input wire logic bypass_neg_rail_in,
    input wire logic bypass_rx_clock_in,
    input wire logic rail_ready,
    output logic pos_rail_out,
    output logic neg_rail_out,
    output logic rail_valid,
    output logic rail_oe,
    output logic line_bypass_sel,
    output logic [5:0] gain_code
);
    function automatic logic [10:0] obs_last(input logic [1:0] sel);
        case (lrgc_pkg::lrgc_obs_t'(sel))
            lrgc_pkg::OBS_32: obs_last = lrgc_pkg::OBS_LAST_32;
            lrgc_pkg::OBS_128: obs_last = lrgc_pkg::OBS_LAST_128;
            lrgc_pkg::OBS_512: obs_last = lrgc_pkg::OBS_LAST_512;
            default: obs_last = lrgc_pkg::OBS_LAST_2048;
        endcase
    endfunction

    function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
        hit = (a == off);
    endfunction

    lrgc_stream_if #(.W(lrgc_pkg::RAIL_W)) sym_if ();
    lrgc_stream_if #(.W(lrgc_pkg::RAIL_W)) out_if ();

    lrgc_fifo #(.W(lrgc_pkg::RAIL_W), .DEPTH(lrgc_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .wr(sym_if.snk),
        .rd(out_if.src)
    );

    // Register file
    logic [7:0] lcfg_r, lcfg_nxt, rxcfg_r, rxcfg_nxt, rdata_r, rdata_nxt;
    logic [5:0] ceil_r, ceil_nxt;
    logic ovf_r, ovf_nxt;
    logic bypass, force_gain, ovf_set;
    logic [1:0] obs_sel;

    assign bypass = lcfg_r[lrgc_pkg::LCFG_BYPASS_BIT];
    assign force_gain = lcfg_r[lrgc_pkg::LCFG_FORCE_GAIN_BIT];
    assign obs_sel = rxcfg_r[lrgc_pkg::RXCFG_OBS_LSB +: 2];

    // Bypass pin synchronisers and filtered levels
    logic [2:0] ck_s_r, ck_s_nxt, p_s_r, p_s_nxt, n_s_r, n_s_nxt;
    logic ck_f_r, ck_f_nxt, p_f_r, p_f_nxt, n_f_r, n_f_nxt;
    logic byp_edge;

    always_comb begin
        ck_s_nxt = {ck_s_r[1:0], bypass_rx_clock_in};
        p_s_nxt = {p_s_r[1:0], bypass_pos_rail_in};
        n_s_nxt = {n_s_r[1:0], bypass_neg_rail_in};
        // A level is taken only once stages two and three agree
        ck_f_nxt = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : ck_f_r;
        p_f_nxt = (p_s_r[1] == p_s_r[2]) ? p_s_r[2] : p_f_r;
        n_f_nxt = (n_s_r[1] == n_s_r[2]) ? n_s_r[2] : n_f_r;
        byp_edge = ck_f_nxt & ~ck_f_r;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ck_s_r <= '0;
            p_s_r <= '0;
            n_s_r <= '0;
            ck_f_r <= 1'b0;
            p_f_r <= 1'b0;
            n_f_r <= 1'b0;
        end else if (clk_en) begin
            ck_s_r <= ck_s_nxt;
            p_s_r <= p_s_nxt;
            n_s_r <= n_s_nxt;
            ck_f_r <= ck_f_nxt;
            p_f_r <= p_f_nxt;
            n_f_r <= n_f_nxt;
        end
    end

    // Symbol source: line slicer or bypass rails
    logic sym_tick;
    logic [1:0] sym_data;

    always_comb begin
        if (bypass) begin
            sym_tick = byp_edge;
            sym_data = {p_f_nxt, n_f_nxt};
        end else begin
            sym_tick = line_symbol_tick;
            sym_data = {line_in_plus, line_in_minus};
        end
    end

    assign sym_if.valid = sym_tick;
    assign sym_if.data = sym_data;
    // No stall is possible on a line; a full FIFO drops and flags
    assign ovf_set = sym_tick & ~sym_if.ready;

    always_comb begin
        lcfg_nxt = lcfg_r;
        rxcfg_nxt = rxcfg_r;
        ceil_nxt = ceil_r;
        ovf_nxt = ovf_r;
        rdata_nxt = rdata_r;
        if (reg_wr) begin
            if (hit(reg_addr, lrgc_pkg::ADDR_LINE_CFG)) begin
                lcfg_nxt = reg_wdata;
            end
            if (hit(reg_addr, lrgc_pkg::ADDR_RX_CFG)) begin
                rxcfg_nxt = reg_wdata;
            end
            if (hit(reg_addr, lrgc_pkg::ADDR_GAIN_CEIL)) begin
                ceil_nxt = reg_wdata[5:0];
            end
        end
        if (reg_rd) begin
            rdata_nxt = 8'h00;
            if (hit(reg_addr, lrgc_pkg::ADDR_LINE_CFG)) begin
                rdata_nxt = lcfg_r;
            end
            if (hit(reg_addr, lrgc_pkg::ADDR_RX_CFG)) begin
                rdata_nxt = rxcfg_r;
            end
            if (hit(reg_addr, lrgc_pkg::ADDR_GAIN_CEIL)) begin
                rdata_nxt = {2'b00, ceil_r};
            end
            if (hit(reg_addr, lrgc_pkg::ADDR_GAIN_STAT)) begin
                rdata_nxt = {ovf_r, ~sym_if.ready, gain_code};
                ovf_nxt = 1'b0;
            end
        end
        // A new overflow beats a clearing read
        if (ovf_set) begin
            ovf_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lcfg_r <= lrgc_pkg::LCFG_RESET;
            rxcfg_r <= lrgc_pkg::RXCFG_RESET;
            ceil_r <= lrgc_pkg::CEIL_RESET;
            ovf_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            lcfg_r <= lcfg_nxt;
            rxcfg_r <= rxcfg_nxt;
            ceil_r <= ceil_nxt;
            ovf_r <= ovf_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Gain loop
    lrgc_pkg::lrgc_agc_t state_r, state_nxt;
    logic [5:0] gain_r, gain_nxt;
    logic [7:0] peak_r, peak_nxt;
    logic [10:0] obs_cnt_r, obs_cnt_nxt;
    logic obs_end, agc_tick;

    // Bypass carries no analog signal, so the loop pauses there
    assign agc_tick = sym_tick & ~bypass;
    // A shortened period takes effect at once
    assign obs_end = (state_r == lrgc_pkg::ST_TRACK) & agc_tick &
                     (obs_cnt_r >= obs_last(obs_sel));

    always_comb begin
        state_nxt = state_r;
        gain_nxt = gain_r;
        peak_nxt = peak_r;
        obs_cnt_nxt = obs_cnt_r;
        case (state_r)
            lrgc_pkg::ST_START: begin
                gain_nxt = ceil_r;
                peak_nxt = lrgc_pkg::PEAK_CLEAR;
                obs_cnt_nxt = '0;
                state_nxt = force_gain ? lrgc_pkg::ST_FIXED : lrgc_pkg::ST_TRACK;
            end
            lrgc_pkg::ST_TRACK: begin
                if (adc_sample_valid && adc_peak_sample > peak_r) begin
                    peak_nxt = adc_peak_sample;
                end
                if (obs_end) begin
                    obs_cnt_nxt = '0;
                    peak_nxt = adc_sample_valid ? adc_peak_sample : lrgc_pkg::PEAK_CLEAR;
                    if (peak_r == lrgc_pkg::PEAK_FULL && gain_r != lrgc_pkg::GAIN_MIN) begin
                        gain_nxt = gain_r - lrgc_pkg::GAIN_STEP;
                    end else if (peak_r < lrgc_pkg::PEAK_LOW && gain_r < ceil_r) begin
                        gain_nxt = gain_r + lrgc_pkg::GAIN_STEP;
                    end
                end else if (agc_tick) begin
                    obs_cnt_nxt = obs_cnt_r + lrgc_pkg::OBS_STEP;
                end
                if (gain_nxt > ceil_r) begin
                    gain_nxt = ceil_r;
                end
                if (force_gain) begin
                    state_nxt = lrgc_pkg::ST_FIXED;
                end
            end
            lrgc_pkg::ST_FIXED: begin
                gain_nxt = ceil_r;
                if (!force_gain) begin
                    state_nxt = lrgc_pkg::ST_START;
                end
            end
            default: begin
                state_nxt = lrgc_pkg::ST_START;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= lrgc_pkg::ST_START;
            gain_r <= lrgc_pkg::CEIL_RESET;
            peak_r <= lrgc_pkg::PEAK_CLEAR;
            obs_cnt_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            gain_r <= gain_nxt;
            peak_r <= peak_nxt;
            obs_cnt_r <= obs_cnt_nxt;
        end
    end

    assign gain_code = gain_r;

    // Rail output stage
    logic pos_r, pos_nxt, neg_r, neg_nxt, valid_r, valid_nxt;
    logic oe_r, oe_nxt, byp_r, byp_nxt, pop;

    assign out_if.ready = ~valid_r | rail_ready;
    assign pop = out_if.valid & out_if.ready;

    always_comb begin
        pos_nxt = pos_r;
        neg_nxt = neg_r;
        valid_nxt = valid_r;
        if (pop) begin
            {pos_nxt, neg_nxt} = out_if.data;
            valid_nxt = 1'b1;
        end else if (rail_ready) begin
            valid_nxt = 1'b0;
        end
        oe_nxt = lcfg_r[lrgc_pkg::LCFG_RAIL_OE_BIT];
        byp_nxt = bypass;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pos_r <= 1'b0;
            neg_r <= 1'b0;
            valid_r <= 1'b0;
            oe_r <= 1'b0;
            byp_r <= 1'b0;
        end else if (clk_en) begin
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            valid_r <= valid_nxt;
            oe_r <= oe_nxt;
            byp_r <= byp_nxt;
        end
    end

    assign pos_rail_out = pos_r;
    assign neg_rail_out = neg_r;
    assign rail_valid = valid_r;
    assign rail_oe = oe_r;
    assign line_bypass_sel = byp_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_bypass_ignores_line: assert property (
        (bypass && !byp_edge && line_symbol_tick) |-> !sym_if.valid)
        else $error("line tick accepted in bypass");
    a_bypass_clock_push: assert property (
        (bypass && byp_edge) |-> (sym_if.valid && sym_if.data == {p_f_nxt, n_f_nxt}))
        else $error("bypass clock edge did not push rails");
    a_line_rails_split: assert property (
        (!bypass && line_symbol_tick) |-> sym_if.data == {line_in_plus, line_in_minus})
        else $error("line rails not split");
    a_rail_out_data: assert property (
        (clk_en && pop) |=> (rail_valid && {pos_rail_out, neg_rail_out} == $past(out_if.data)))
        else $error("rail output mismatch");
    a_gain_down_full: assert property (
        (clk_en && obs_end && !force_gain && peak_r == 8'hFF && gain_r != 6'h00
         && gain_r <= ceil_r) |=> gain_r == $past(gain_r) - 6'h01)
        else $error("gain not reduced at full scale");
    a_gain_up_low: assert property (
        (clk_en && obs_end && !force_gain && peak_r < 8'hC0 && gain_r < ceil_r)
        |=> gain_r == $past(gain_r) + 6'h01)
        else $error("gain not raised on low peak");
    a_gain_limit_cap: assert property (
        (clk_en && state_r == lrgc_pkg::ST_TRACK) |=> gain_r <= $past(ceil_r))
        else $error("gain above ceiling");
    a_start_at_ceiling: assert property (
        (clk_en && state_r == lrgc_pkg::ST_START)
        |=> (gain_r == $past(ceil_r) && obs_cnt_r == 11'h000))
        else $error("gain loop did not start at ceiling");
    a_fixed_gain: assert property (
        (clk_en && state_r == lrgc_pkg::ST_FIXED) |=> gain_r == $past(ceil_r))
        else $error("fixed gain not applied");
    a_force_selects: assert property (
        (clk_en && force_gain && state_r == lrgc_pkg::ST_TRACK)
        |=> state_r == lrgc_pkg::ST_FIXED)
        else $error("force gain ignored");
    a_obs_restart: assert property (
        (clk_en && obs_end) |=> obs_cnt_r == 11'h000)
        else $error("observation count not restarted");
    a_peak_clear: assert property (
        (clk_en && obs_end && !adc_sample_valid) |=> peak_r == 8'h00)
        else $error("peak not cleared");
    a_status_gain: assert property (
        (clk_en && reg_rd && reg_addr == 9'h029) |=> reg_rdata[5:0] == $past(gain_r))
        else $error("status gain mismatch");
    a_oe_off_reset: assert property (@(posedge mclk) disable iff (1'b0)
        reset |=> !rail_oe)
        else $error("outputs enabled after reset");

    c_gain_step_down: cover property (obs_end && peak_r == 8'hFF);
    c_bypass_symbol: cover property (bypass && byp_edge);
    c_fifo_full: cover property (!sym_if.ready);
    c_fixed_mode: cover property (state_r == lrgc_pkg::ST_FIXED);
endmodule // lrgc_top

/* File: sim/lrgc_line_model.sv */
// Line-side partner: sliced symbols, converter peaks and bypass pins.
// Assumes the bench calls its tasks; all pins change on the falling edge.
`timescale 1ns/10ps
module lrgc_line_model (
    input wire logic mclk,
    output logic line_in_plus,
    output logic line_in_minus,
    output logic line_symbol_tick,
    output logic [7:0] adc_peak_sample,
    output logic adc_sample_valid,
    output logic bypass_pos_rail_in,
    output logic bypass_neg_rail_in,
    output logic bypass_rx_clock_in
);
    initial begin
        line_in_plus = 1'b0;
        line_in_minus = 1'b0;
        line_symbol_tick = 1'b0;
        adc_peak_sample = 8'h00;
        adc_sample_valid = 1'b0;
        bypass_pos_rail_in = 1'b0;
        bypass_neg_rail_in = 1'b0;
        bypass_rx_clock_in = 1'b0;
    end

    // Lines invert after the tick so stale data never looks valid
    task automatic send_line(input logic p, input logic n);
        @(negedge mclk);
        line_in_plus = p;
        line_in_minus = n;
        line_symbol_tick = 1'b1;
        @(negedge mclk);
        line_symbol_tick = 1'b0;
        line_in_plus = ~p;
        line_in_minus = ~n;
    endtask

    task automatic send_ticks(input int cnt);
        repeat (cnt) send_line(1'b0, 1'b0);
    endtask

    task automatic set_peak(input logic [7:0] v);
        @(negedge mclk);
        adc_peak_sample = v;
        adc_sample_valid = 1'b1;
    endtask

    task automatic drop_peak();
        @(negedge mclk);
        adc_sample_valid = 1'b0;
    endtask

    // Clock stands low between symbols; rails held across the high phase
    task automatic send_byp(input logic p, input logic n);
        @(negedge mclk);
        bypass_pos_rail_in = p;
        bypass_neg_rail_in = n;
        repeat (4) @(negedge mclk);
        bypass_rx_clock_in = 1'b1;
        repeat (4) @(negedge mclk);
        bypass_rx_clock_in = 1'b0;
        repeat (4) @(negedge mclk);
        bypass_pos_rail_in = ~p;
        bypass_neg_rail_in = ~n;
    endtask
endmodule // lrgc_line_model

/* File: sim/lrgc_top_bench.sv */
// Self-checking bench for the receive line gain control block.
// Assumes the line model drives the line side; bench owns registers.
`timescale 1ns/10ps
module lrgc_top_bench;
    logic mclk, reset, clk_en, reg_wr, reg_rd, rail_ready;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd, apk;
    logic pos_rail_out, neg_rail_out, rail_valid, rail_oe, line_bypass_sel;
    logic [5:0] gain_code;
    logic lp, lm, tick, avld, bp, bn, bc;
    logic [1:0] rx_q[$];
    int error_cnt = 0;
    int n_tests = 0;

    lrgc_top i_lrgc_top (.mclk(mclk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_in_plus(lp),
        .line_in_minus(lm), .line_symbol_tick(tick), .adc_peak_sample(apk),
        .adc_sample_valid(avld), .bypass_pos_rail_in(bp),
        .bypass_neg_rail_in(bn), .bypass_rx_clock_in(bc),
        .rail_ready(rail_ready), .pos_rail_out(pos_rail_out),
        .neg_rail_out(neg_rail_out), .rail_valid(rail_valid),
        .rail_oe(rail_oe), .line_bypass_sel(line_bypass_sel),
        .gain_code(gain_code));

    lrgc_line_model i_lrgc_line_model (.mclk(mclk), .line_in_plus(lp),
        .line_in_minus(lm), .line_symbol_tick(tick), .adc_peak_sample(apk),
        .adc_sample_valid(avld), .bypass_pos_rail_in(bp),
        .bypass_neg_rail_in(bn), .bypass_rx_clock_in(bc));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rail_valid === 1'b1 && rail_ready === 1'b1) begin
            rx_q.push_back({pos_rail_out, neg_rail_out});
        end
    end

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rdr(input logic [8:0] a);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        rd = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic t_reset();
        chk({7'h00, rail_oe}, 8'h00);
        chk({2'b00, gain_code}, 8'h3F);
        rdr(lrgc_pkg::ADDR_GAIN_CEIL);
        chk(rd, 8'h3F);
        rdr(lrgc_pkg::ADDR_LINE_CFG);
        chk(rd, 8'h00);
        rdr(lrgc_pkg::ADDR_GAIN_STAT);
        chk(rd, 8'h3F);
        rdr(9'h000);
        chk(rd, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_fixed();
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'hFF);
        rdr(lrgc_pkg::ADDR_GAIN_CEIL);
        chk(rd, 8'h3F);
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'h15);
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h41);
        idle(3);
        chk({2'b00, gain_code}, 8'h15);
        rdr(lrgc_pkg::ADDR_GAIN_STAT);
        chk(rd & 8'h3F, 8'h15);
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'h2A);
        idle(3);
        chk({2'b00, gain_code}, 8'h2A);
        $display("test fixed gain done");
    endtask

    task automatic t_line();
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h01);
        rx_q.delete();
        i_lrgc_line_model.send_line(1'b1, 1'b0);
        i_lrgc_line_model.send_line(1'b0, 1'b1);
        i_lrgc_line_model.send_line(1'b0, 1'b0);
        idle(10);
        chk({7'h00, rail_oe}, 8'h01);
        chk(8'(rx_q.size()), 8'h03);
        chk({6'h00, rx_q[0]}, 8'h02);
        chk({6'h00, rx_q[1]}, 8'h01);
        chk({6'h00, rx_q[2]}, 8'h00);
        $display("test line rails done");
    endtask

    task automatic t_bypass();
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h81);
        idle(6);
        chk({7'h00, line_bypass_sel}, 8'h01);
        rx_q.delete();
        i_lrgc_line_model.send_line(1'b1, 1'b0);
        idle(10);
        chk(8'(rx_q.size()), 8'h00);
        i_lrgc_line_model.send_byp(1'b1, 1'b0);
        i_lrgc_line_model.send_byp(1'b0, 1'b1);
        idle(10);
        chk(8'(rx_q.size()), 8'h02);
        chk({6'h00, rx_q[0]}, 8'h02);
        chk({6'h00, rx_q[1]}, 8'h01);
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h01);
        $display("test bypass done");
    endtask

    // Passing through fixed gain restarts the loop, aligning the period count
    task automatic agc_start(input logic [1:0] p);
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'h3F);
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h41);
        wr(lrgc_pkg::ADDR_RX_CFG, {6'h00, p});
        i_lrgc_line_model.set_peak(8'hFF);
        wr(lrgc_pkg::ADDR_LINE_CFG, 8'h01);
        idle(3);
        chk({2'b00, gain_code}, 8'h3F);
    endtask

    task automatic t_period(input logic [1:0] p);
        int last;
        last = 32 << (2 * p);
        agc_start(p);
        i_lrgc_line_model.send_ticks(last - 1);
        idle(2);
        chk({2'b00, gain_code}, 8'h3F);
        i_lrgc_line_model.send_ticks(1);
        idle(2);
        chk({2'b00, gain_code}, 8'h3E);
        $display("test period %0d done", last);
    endtask

    task automatic t_track();
        agc_start(2'b00);
        i_lrgc_line_model.send_ticks(31);
        i_lrgc_line_model.set_peak(8'hE0);
        i_lrgc_line_model.send_ticks(1);
        idle(2);
        chk({2'b00, gain_code}, 8'h3E);
        i_lrgc_line_model.send_ticks(31);
        i_lrgc_line_model.set_peak(8'h80);
        i_lrgc_line_model.send_ticks(1);
        idle(2);
        chk({2'b00, gain_code}, 8'h3E);
        i_lrgc_line_model.send_ticks(32);
        idle(2);
        chk({2'b00, gain_code}, 8'h3F);
        i_lrgc_line_model.send_ticks(32);
        idle(2);
        chk({2'b00, gain_code}, 8'h3F);
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'h20);
        idle(3);
        chk({2'b00, gain_code}, 8'h20);
        i_lrgc_line_model.set_peak(8'hFF);
        i_lrgc_line_model.send_ticks(32);
        idle(2);
        chk({2'b00, gain_code}, 8'h1F);
        // Sampling stops; a stale full-scale peak must not outlive its period
        i_lrgc_line_model.drop_peak();
        i_lrgc_line_model.send_ticks(32);
        idle(2);
        chk({2'b00, gain_code}, 8'h1E);
        i_lrgc_line_model.send_ticks(32);
        idle(2);
        chk({2'b00, gain_code}, 8'h1F);
        $display("test tracking done");
    endtask

    task automatic t_fifo();
        int n;
        @(negedge mclk);
        rail_ready = 1'b0;
        rx_q.delete();
        i_lrgc_line_model.send_ticks(18);
        rdr(lrgc_pkg::ADDR_GAIN_STAT);
        chk(rd & 8'hC0, 8'hC0);
        rdr(lrgc_pkg::ADDR_GAIN_STAT);
        chk(rd & 8'hC0, 8'h40);
        rail_ready = 1'b1;
        idle(40);
        // Sixteen FIFO words plus the output register
        n = rx_q.size();
        chk(8'(n), 8'h11);
        $display("test fifo overflow done");
    endtask

    // Clock enable low must hold every register, FIFO included
    task automatic t_freeze();
        @(negedge mclk);
        clk_en = 1'b0;
        rx_q.delete();
        wr(lrgc_pkg::ADDR_GAIN_CEIL, 8'h05);
        i_lrgc_line_model.send_line(1'b1, 1'b1);
        idle(4);
        chk({2'b00, gain_code}, 8'h1F);
        chk(8'(rx_q.size()), 8'h00);
        clk_en = 1'b1;
        rdr(lrgc_pkg::ADDR_GAIN_CEIL);
        chk(rd, 8'h20);
        reset = 1'b1;
        idle(2);
        reset = 1'b0;
        chk({7'h00, rail_oe}, 8'h00);
        chk({2'b00, gain_code}, 8'h3F);
        rdr(lrgc_pkg::ADDR_LINE_CFG);
        chk(rd, 8'h00);
        $display("test freeze and reset done");
    endtask

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        rail_ready = 1'b1;
        idle(7);
        reset = 1'b0;
        t_reset();
        t_fixed();
        t_line();
        t_bypass();
        for (int p = 0; p < 4; p++) begin
            t_period(2'(p));
        end
        t_track();
        t_fifo();
        t_freeze();
        tally_and_finish();
    end

    // About 6200 cycles are needed; 20000 leaves ample margin
    initial begin
        #200_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // lrgc_top_bench
